// ### dv/test_utiu_core.sv
// Bench for the interpolate unit: APB registers, register and table
// interpolation at all sizes and roundings, refused and illegal requests.
`timescale 1ns/1ns
`define CHECK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module test_utiu_core;
    import utiu_pkg::*;
    logic        clk, rst_b, ce, req_valid, req_ready, mem_ack, slow;
    logic        psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] mem_rdata, pwdata, prdata, dx, a0, a1, m, q;
    logic [15:0] ext;
    logic [3:0]  f;
    logic [1:0]  sz;
    logic [2:0]  nb;
    utiu_req_t   req;
    utiu_mem_t   mem;
    utiu_wb_t    wb;
    int          fail_count, checks_done;
    localparam logic [5:0] EA_OK [7] = '{6'h10, 6'h29, 6'h32, 6'h38,
                                         6'h39, 6'h3a, 6'h3b};
    localparam logic [5:0] EA_BAD [5] = '{6'h02, 6'h08, 6'h18, 6'h20, 6'h3c};
    utiu_core utiu_core_inst (.clk(clk), .rst_b(rst_b), .ce(ce),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .mem(mem),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .wb(wb), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    utiu_mem_model utiu_mem_model_inst (.clk(clk), .rst_b(rst_b),
        .slow(slow), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    always #50 clk = ~clk;
    ////////////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rq,
                       output logic re);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // Wait for the edge that samples pready high; take the answer there.
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic exec(input logic [15:0] op, input logic [15:0] x,
                        input logic [31:0] ea, input logic [31:0] d,
                        input logic [31:0] ym, input logic [31:0] yn);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{op, x, ea, d, ym, yn};
        // The request is taken at the edge that samples req_ready high.
        do
            @(posedge clk);
        while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        @(negedge clk);
        for (n = 0; wb.done !== 1'b1 && n < 50; n++)
            @(negedge clk);
        `CHECK(wb.done, 1'b1)
    endtask
    task automatic check_wb(input logic [31:0] a, input logic [31:0] b,
                            input logic [31:0] x, input logic [15:0] w);
        logic [41:0] s;
        logic [31:0] k;
        logic [31:0] r;
        k = w[7:6] == SZ_BYTE ? 32'hff : w[7:6] == SZ_WORD ? 32'hffff :
            32'hffff_ffff;
        s = ({10'h0, a & k} << 8)
            + ({10'h0, b & k} - {10'h0, a & k}) * {34'h0, x[7:0]};
        r = w[EXT_R_BIT] ? s[31:0] :
            (x & ~k) | ((s[39:8] + 32'(s[7])) & k);
        `CHECK(wb.value, r)
        `CHECK(wb.value[7:0], r[7:0])
        `CHECK({wb.reg_we, wb.ccr_we, wb.reg_idx}, {2'h3, w[14:12]})
        `CHECK({wb.n, wb.z, wb.c}, {w[EXT_R_BIT] ? r[31] :
            |(r & k & ~(k >> 1)), (r & (w[EXT_R_BIT] ? ~32'h0 : k)) == 0,
            1'b0})
        `CHECK(wb.v, w[EXT_R_BIT] && w[7:6] == SZ_LONG && |s[41:31])
    endtask
    task automatic complete_run();
        $display("checks=%0d failures=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        {clk, rst_b, req_valid, slow, psel, penable, pwrite} = '0;
        {paddr, pwdata, req} = '0;
        ce = 1'b1;
        fail_count = 0;
        checks_done = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0, q, e);
        `CHECK(q, 32'h1)
        apb(1'b0, ADDR_STATUS, 32'h0, q, e);
        `CHECK(q, 32'h0)
        apb(1'b0, 12'h010, 32'h0, q, e);
        `CHECK({e, q}, 33'h1_0000_0000)
        apb(1'b1, ADDR_CTRL, 32'h0, q, e);
        @(negedge clk);
        `CHECK(req_ready, 1'b0)
        apb(1'b1, ADDR_CTRL, 32'h1, q, e);
        @(posedge clk);
        ce <= 1'b0;
        @(negedge clk);
        `CHECK({req_ready, pready}, 2'h0)
        @(posedge clk);
        ce <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            ext = {1'b0, 3'(i), 1'b0, i[0], 2'h0, 2'(i >> 1), 6'h5};
            dx = 32'ha5a5_3780 + 32'(i);
            exec({OP_PATTERN, 6'h02}, ext, 32'h0, dx, 32'h8765_4330,
                 32'h1234_9a11);
            check_wb(32'h8765_4330, 32'h1234_9a11, dx, ext);
        end
        exec({OP_PATTERN, 6'h01}, 16'h3005, 32'h0, 32'h1234_56c0,
             32'hffff_ff00, 32'h7777_7700);
        check_wb(32'hffff_ff00, 32'h7777_7700, 32'h1234_56c0, 16'h3005);
        for (int i = 0; i < 7; i++)
        begin
            sz = 2'(i % 3);
            slow <= i[1];
            nb = sz == SZ_BYTE ? 3'h1 : sz == SZ_WORD ? 3'h2 : 3'h4;
            m = sz == SZ_BYTE ? 32'hff : sz == SZ_WORD ? 32'hffff :
                32'hffff_ffff;
            dx = {16'hf00f, 8'(i + 3), 8'(8'h40 + i)};
            a0 = 32'h40 + 32'(i + 3) * 32'(nb);
            a1 = a0 + 32'(nb);
            utiu_mem_model_inst.ent[a0[7:0]] = 32'h5e6f_7a8b & m;
            utiu_mem_model_inst.ent[a1[7:0]] = 32'hc1d2_e3f4 & m;
            ext = {1'b0, 3'(i), 1'b0, i[0], 2'h1, sz, 6'h0};
            exec({OP_PATTERN, EA_OK[i]}, ext, 32'h40, dx, 32'h1357_9bdf,
                 32'h2468_ace0);
            check_wb(32'h5e6f_7a8b, 32'hc1d2_e3f4, dx, ext);
            `CHECK({utiu_mem_model_inst.seen[0],
                    utiu_mem_model_inst.seen[1]}, {a0, a1})
        end
        for (int i = 0; i < 5; i++)
        begin
            f = {wb.n, wb.z, wb.v, wb.c};
            exec({OP_PATTERN, EA_BAD[i]}, i == 0 ? 16'h00c5 : 16'h0100,
                 32'h40, 32'h0000_0101, 32'h0, 32'h0);
            `CHECK({wb.illegal, wb.reg_we, wb.ccr_we}, 3'h4)
            `CHECK({wb.n, wb.z, wb.v, wb.c}, f)
        end
        apb(1'b0, ADDR_STATUS, 32'h0, q, e);
        `CHECK(q[1], 1'b1)
        complete_run();
    end
    initial
    begin
        #(100 * 20000);
        fail_count++;
        complete_run();
    end
endmodule

// ### dv/utiu_core_chk.sv
// Checker for the interpolate unit's instruction, memory and result ports.
// Bound onto utiu_core; one clock, reset rst_b active low.
`timescale 1ns/1ns
module utiu_core_chk
(
    input wire logic                clk,
    input wire logic                rst_b,
    input wire logic                ce,
    input wire logic                req_valid,
    input wire logic                req_ready,
    input wire utiu_pkg::utiu_req_t req,
    input wire utiu_pkg::utiu_mem_t mem,
    input wire utiu_pkg::utiu_wb_t  wb
);
    import utiu_pkg::*;
    logic [15:0] ext_r;
    logic [31:0] dx_r;
    logic [31:0] ea_r;
    logic [2:0]  nb;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    assign nb = ext_r[7:6] == SZ_BYTE ? 3'h1 :
                ext_r[7:6] == SZ_WORD ? 3'h2 : 3'h4;
    // Operands of the instruction in flight.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ext_r <= '0;
            dx_r  <= '0;
            ea_r  <= '0;
        end
        else if (ce && req_valid && req_ready)
        begin
            ext_r <= req.ext_word;
            dx_r  <= req.dx_val;
            ea_r  <= req.ea_addr;
        end
    end
    ////////////////////////////////////////
    a_illegal_quiet:
        assert property (wb.illegal |-> wb.done && !wb.reg_we && !wb.ccr_we)
        else $error("Illegal instruction wrote state.");
    a_carry_clear:
        assert property (wb.ccr_we |-> !wb.c)
        else $error("Carry set by a result.");
    a_flags_hold:
        assert property (!wb.ccr_we |-> $stable({wb.n, wb.z, wb.v, wb.c}))
        else $error("Flags moved without a flag write.");
    a_keep_upper:
        assert property (wb.reg_we && !ext_r[EXT_R_BIT]
            && ext_r[7:6] != SZ_LONG |-> wb.value[31:16] == dx_r[31:16]
            && (ext_r[7:6] != SZ_BYTE || wb.value[15:8] == dx_r[15:8]))
        else $error("Rounded result touched bits above its size.");
    a_v_long_only:
        assert property (wb.ccr_we && !(ext_r[EXT_R_BIT]
            && ext_r[7:6] == SZ_LONG) |-> !wb.v)
        else $error("Overflow set outside unrounded long.");
    a_dest_index:
        assert property (wb.reg_we |-> wb.reg_idx == ext_r[14:12])
        else $error("Result written to the wrong register.");
    a_table_base:
        assert property ($rose(mem.rd_req)
            |-> mem.addr == ea_r + 32'(dx_r[15:8]) * 32'(nb))
        else $error("First table read at the wrong address.");
    a_reg_latency:
        assert property (ce && req_valid && req_ready
            && req.op_word[15:3] == {OP_PATTERN, EA_DREG}
            && (req.ext_word & 16'h8b00) == 16'h0
            && req.ext_word[7:6] != 2'h3 |-> ##2 wb.done && wb.reg_we)
        else $error("Register interpolation late.");
endmodule
bind utiu_core utiu_core_chk utiu_core_chk_inst (.clk(clk), .rst_b(rst_b),
    .ce(ce), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .mem(mem), .wb(wb));

// ### dv/utiu_mem_model.sv
// Operand memory answering table reads with a one-cycle ack.
// Entries are loaded by the bench; slow adds three wait cycles.
`timescale 1ns/1ns
module utiu_mem_model
(
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                slow,
    input  wire utiu_pkg::utiu_mem_t mem,
    output      logic                mem_ack,
    output      logic [31:0]         mem_rdata
);
    import utiu_pkg::*;
    logic [31:0] ent [256];
    logic [31:0] seen [2];
    logic [1:0]  wait_r;
    logic        idx_r;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mem_ack   <= 1'b0;
            mem_rdata <= 32'h0;
            wait_r    <= 2'h0;
            idx_r     <= 1'b0;
        end
        else if (mem_ack)
        begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
        else if (mem.rd_req && (wait_r == 2'h3 || !slow))
        begin
            // Bits above the entry size carry ones the unit must drop.
            mem_ack     <= 1'b1;
            mem_rdata   <= ent[mem.addr[7:0]] | (mem.size == SZ_BYTE ?
                32'hffff_ff00 : mem.size == SZ_WORD ? 32'hffff_0000 : 32'h0);
            seen[idx_r] <= mem.addr;
            idx_r       <= ~idx_r;
            wait_r      <= 2'h0;
        end
        else if (mem.rd_req)
        begin
            wait_r <= wait_r + 2'h1;
        end
    end
endmodule

// ### hw/utiu_core.sv
// Unsigned table lookup and interpolate execution unit with APB registers.
// Assumes the sequencer supplies the computed effective address and the
// register values, and a memory port answers reads with a one-cycle ack.
//
// Behaviour
// - Table offset is integer byte of destination times operand size.
// - Difference of next minus selected entry, scaled by fraction, added.
// - Points from memory or registers; rounded divides by 256.
// - Register mode uses both operand registers and only the fraction byte.
// - Entries are unsigned and zero extended from 8, 16 or 32 bits.
// - Unrounded results are zero extended to fill the destination.
// - Rounding adds one when the adjusted fraction is at least half.
// - Rounded result writes only the bits of the selected size.
// - Unrounded integer goes to bits 15..8, 23..8 or 31..8.
// - Unrounded fraction always lands in the lowest destination byte.
// - N from msb, Z on zero, X kept, C always cleared.
// - V set when unrounded long integer exceeds signed 24-bit range.
// - Table form: fixed pattern, effective address, extension mode 01.
// - Register form: mode zero, operand registers in both words.
// - Size field 00 byte, 01 word, 10 long.
// - Table mode accepts control addressing modes only.
// - Effective address mode zero selects register interpolation.
// - Rounding bit 0 gives rounded, 1 gives unrounded output.
// - Interpolation resolves one 256th of an entry step.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module utiu_core
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              ce,
    input  wire logic              req_valid,
    output      logic              req_ready,
    input  wire utiu_pkg::utiu_req_t req,
    output      utiu_pkg::utiu_mem_t mem,
    input  wire logic              mem_ack,
    input  wire logic [31:0]       mem_rdata,
    output      utiu_pkg::utiu_wb_t  wb,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output      logic [31:0]       prdata,
    output      logic              pready,
    output      logic              pslverr
);
    import utiu_pkg::*;

    utiu_state_t st_r;
    utiu_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic [31:0] zext(input logic [31:0] v,
                                         input logic [1:0]  sz);
        logic [31:0] r;
        r = v;
        if (sz == SZ_BYTE)
        begin
            r = {24'h0, v[7:0]};
        end
        else if (sz == SZ_WORD)
        begin
            r = {16'h0, v[15:0]};
        end
        return r;
    endfunction

    function automatic logic [31:0] size_bytes(input logic [1:0] sz);
        logic [31:0] r;
        r = 32'h1;
        if (sz == SZ_WORD)
        begin
            r = 32'h2;
        end
        else if (sz == SZ_LONG)
        begin
            r = 32'h4;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decode of an incoming request.

    logic [2:0]  ea_mode;
    logic [2:0]  ea_reg;
    logic [1:0]  dec_size;
    logic        reg_mode;
    logic        ea_ok;
    logic        dec_illegal;
    logic [31:0] tbl_addr0;

    assign ea_mode  = req.op_word[EA_MODE_HI:EA_MODE_LO];
    assign ea_reg   = req.op_word[EA_REG_HI:EA_REG_LO];
    assign dec_size = req.ext_word[EXT_SZ_HI:EXT_SZ_LO];
    assign reg_mode = (ea_mode == EA_DREG);

    always_comb
    begin
        ea_ok = 1'b0;
        if (ea_mode == EA_IND || ea_mode == EA_DISP ||
            ea_mode == EA_INDEX)
        begin
            ea_ok = 1'b1;
        end
        else if (ea_mode == EA_OTHER)
        begin
            ea_ok = (ea_reg <= EA_OTH_MAX);
        end
    end

    always_comb
    begin
        dec_illegal = 1'b0;
        if (req.op_word[OP_PAT_HI:OP_PAT_LO] != OP_PATTERN ||
            req.ext_word[EXT_Z15] || req.ext_word[EXT_Z11])
        begin
            dec_illegal = 1'b1;
        end
        else if (dec_size == 2'h3)
        begin
            dec_illegal = 1'b1;
        end
        else if (reg_mode)
        begin
            dec_illegal = (req.ext_word[EXT_MD_HI:EXT_MD_LO]
                           != EXT_MD_REG);
        end
        else
        begin
            dec_illegal = !ea_ok ||
                          (req.ext_word[EXT_MD_HI:EXT_MD_LO]
                           != EXT_MD_TBL);
        end
    end

    // Entry address: base plus integer part scaled by the entry size.
    assign tbl_addr0 = req.ea_addr +
                       ({24'h0, req.dx_val[15:8]} *
                        size_bytes(dec_size));

    ////////////////////////////////////////////////////////////////////////
    // Interpolation datapath, fed from the captured entries.

    logic [7:0]  frac;
    logic [32:0] diff;
    logic [41:0] prod;
    logic [41:0] full;
    logic [41:0] rnd_t;
    logic [41:0] rnd_q;
    logic [41:0] rnd_sum;
    logic [31:0] rnd;
    logic [31:0] res_val;
    logic        res_n;
    logic        res_z;
    logic        res_v;

    assign frac = st_r.dx_val[FRAC_W-1:0];
    assign diff = {1'b0, st_r.e1} - {1'b0, st_r.e0};
    assign prod = {{9{diff[32]}}, diff} * {34'h0, frac};
    assign full = {2'h0, st_r.e0, 8'h0} + prod;
    assign rnd_t = prod + RND_HALF;
    assign rnd_q = {{8{rnd_t[41]}}, rnd_t[41:8]};
    assign rnd_sum = {10'h0, st_r.e0} + rnd_q;
    assign rnd = rnd_sum[31:0];

    always_comb
    begin
        res_val = st_r.dx_val;
        res_n   = 1'b0;
        res_z   = 1'b0;
        res_v   = 1'b0;
        if (!st_r.round_n)
        begin
            if (st_r.size == SZ_BYTE)
            begin
                res_val = {st_r.dx_val[31:8], rnd[7:0]};
                res_n   = rnd[7];
                res_z   = (rnd[7:0] == 8'h0);
            end
            else if (st_r.size == SZ_WORD)
            begin
                res_val = {st_r.dx_val[31:16], rnd[15:0]};
                res_n   = rnd[15];
                res_z   = (rnd[15:0] == 16'h0);
            end
            else
            begin
                res_val = rnd;
                res_n   = rnd[31];
                res_z   = (rnd == 32'h0);
            end
        end
        else
        begin
            if (st_r.size == SZ_BYTE)
            begin
                res_val = {16'h0, full[15:0]};
            end
            else if (st_r.size == SZ_WORD)
            begin
                res_val = {8'h0, full[23:0]};
            end
            else
            begin
                res_val = full[31:0];
                res_v   = !(&full[41:31]) && (|full[41:31]);
            end
            res_n = res_val[31];
            res_z = (res_val == 32'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode.

    logic        apb_setup;
    logic        apb_access;
    logic        addr_bad;
    logic [31:0] rd_mux;

    assign apb_setup  = psel && !penable;
    assign apb_access = psel && penable;

    always_comb
    begin
        addr_bad = 1'b0;
        rd_mux   = 32'h0;
        if (paddr == ADDR_CTRL)
        begin
            rd_mux = {31'h0, st_r.ctrl_en};
        end
        else if (paddr == ADDR_STATUS)
        begin
            rd_mux = {24'h0, st_r.wb.n, st_r.wb.z, st_r.wb.v, st_r.wb.c,
                      2'h0, st_r.last_illegal, (st_r.fsm != ST_IDLE)};
        end
        else if (paddr == ADDR_RESULT)
        begin
            rd_mux = st_r.wb.value;
        end
        else
        begin
            addr_bad = 1'b1;
        end
    end

    assign pready  = ce;
    assign pslverr = apb_access && addr_bad;
    assign prdata  = st_r.prdata;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and state update.

    assign req_ready = ce && (st_r.fsm == ST_IDLE) && st_r.ctrl_en;
    assign mem       = st_r.mem;
    assign wb        = st_r.wb;

    always_comb
    begin
        st_nxt            = st_r;
        st_nxt.wb.done    = 1'b0;
        st_nxt.wb.illegal = 1'b0;
        st_nxt.wb.reg_we  = 1'b0;
        st_nxt.wb.ccr_we  = 1'b0;
        if (apb_setup && !pwrite)
        begin
            st_nxt.prdata = rd_mux;
        end
        if (apb_access && pwrite && paddr == ADDR_CTRL)
        begin
            st_nxt.ctrl_en = pwdata[0];
        end
        case (st_r.fsm)
            ST_IDLE:
            begin
                if (req_valid && req_ready)
                begin
                    st_nxt.size    = dec_size;
                    st_nxt.round_n = req.ext_word[EXT_R_BIT];
                    st_nxt.dx_idx  = req.ext_word[EXT_DX_HI:EXT_DX_LO];
                    st_nxt.dx_val  = req.dx_val;
                    if (dec_illegal)
                    begin
                        st_nxt.wb.illegal    = 1'b1;
                        st_nxt.wb.done       = 1'b1;
                        st_nxt.last_illegal  = 1'b1;
                    end
                    else if (reg_mode)
                    begin
                        st_nxt.e0  = zext(req.dym_val, dec_size);
                        st_nxt.e1  = zext(req.dyn_val, dec_size);
                        st_nxt.fsm = ST_CALC;
                        st_nxt.last_illegal = 1'b0;
                    end
                    else
                    begin
                        st_nxt.mem.rd_req = 1'b1;
                        st_nxt.mem.addr   = tbl_addr0;
                        st_nxt.mem.size   = dec_size;
                        st_nxt.fsm        = ST_RD0;
                        st_nxt.last_illegal = 1'b0;
                    end
                end
            end
            ST_RD0:
            begin
                if (mem_ack)
                begin
                    st_nxt.e0       = zext(mem_rdata, st_r.size);
                    st_nxt.mem.addr = st_r.mem.addr +
                                      size_bytes(st_r.size);
                    st_nxt.fsm      = ST_RD1;
                end
            end
            ST_RD1:
            begin
                if (mem_ack)
                begin
                    st_nxt.e1         = zext(mem_rdata, st_r.size);
                    st_nxt.mem.rd_req = 1'b0;
                    st_nxt.fsm        = ST_CALC;
                end
            end
            ST_CALC:
            begin
                st_nxt.wb.done    = 1'b1;
                st_nxt.wb.reg_we  = 1'b1;
                st_nxt.wb.reg_idx = st_r.dx_idx;
                st_nxt.wb.value   = res_val;
                st_nxt.wb.ccr_we  = 1'b1;
                st_nxt.wb.n       = res_n;
                st_nxt.wb.z       = res_z;
                st_nxt.wb.v       = res_v;
                st_nxt.wb.c       = 1'b0;
                st_nxt.fsm        = ST_IDLE;
            end
            default:
            begin
                st_nxt.fsm = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= UTIU_ST_RST;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
        end
    end

endmodule

// ### hw/utiu_pkg.sv
// Constants, field layouts and carrier types of the unsigned table
// interpolate unit.
// Assumes a 32-bit operand path and a sequencer on the same clock.
package utiu_pkg;

    // Instruction layout: first word and extension word.
    localparam logic [9:0] OP_PATTERN  = 10'h3e0;
    localparam int         OP_PAT_HI   = 15;
    localparam int         OP_PAT_LO   = 6;
    localparam int         EA_MODE_HI  = 5;
    localparam int         EA_MODE_LO  = 3;
    localparam int         EA_REG_HI   = 2;
    localparam int         EA_REG_LO   = 0;
    localparam int         EXT_Z15     = 15;
    localparam int         EXT_DX_HI   = 14;
    localparam int         EXT_DX_LO   = 12;
    localparam int         EXT_Z11     = 11;
    localparam int         EXT_R_BIT   = 10;
    localparam int         EXT_MD_HI   = 9;
    localparam int         EXT_MD_LO   = 8;
    localparam int         EXT_SZ_HI   = 7;
    localparam int         EXT_SZ_LO   = 6;
    localparam logic [1:0] EXT_MD_TBL  = 2'h1;
    localparam logic [1:0] EXT_MD_REG  = 2'h0;

    // Size codes.
    localparam logic [1:0] SZ_BYTE     = 2'h0;
    localparam logic [1:0] SZ_WORD     = 2'h1;
    localparam logic [1:0] SZ_LONG     = 2'h2;

    // Effective address modes.
    localparam logic [2:0] EA_DREG     = 3'h0;
    localparam logic [2:0] EA_IND      = 3'h2;
    localparam logic [2:0] EA_DISP     = 3'h5;
    localparam logic [2:0] EA_INDEX    = 3'h6;
    localparam logic [2:0] EA_OTHER    = 3'h7;
    localparam logic [2:0] EA_OTH_MAX  = 3'h3;

    // Fraction and rounding.
    localparam int         FRAC_W      = 8;
    localparam logic [41:0] RND_HALF   = 42'h80;

    // Register map, byte addresses.
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_RESULT = 12'h008;
    localparam logic        CTRL_EN_RST = 1'b1;

    typedef enum logic [1:0] {ST_IDLE, ST_RD0, ST_RD1, ST_CALC} utiu_fsm_t;

    typedef struct packed {
        logic [15:0] op_word;
        logic [15:0] ext_word;
        logic [31:0] ea_addr;
        logic [31:0] dx_val;
        logic [31:0] dym_val;
        logic [31:0] dyn_val;
    } utiu_req_t;

    typedef struct packed {
        logic        rd_req;
        logic [31:0] addr;
        logic [1:0]  size;
    } utiu_mem_t;

    typedef struct packed {
        logic        done;
        logic        illegal;
        logic        reg_we;
        logic [2:0]  reg_idx;
        logic [31:0] value;
        logic        ccr_we;
        logic        n;
        logic        z;
        logic        v;
        logic        c;
    } utiu_wb_t;

    typedef struct packed {
        utiu_fsm_t   fsm;
        logic        ctrl_en;
        logic        last_illegal;
        logic        round_n;
        logic [1:0]  size;
        logic [2:0]  dx_idx;
        logic [31:0] dx_val;
        logic [31:0] e0;
        logic [31:0] e1;
        utiu_mem_t   mem;
        utiu_wb_t    wb;
        logic [31:0] prdata;
    } utiu_state_t;

    localparam utiu_state_t UTIU_ST_RST = '{
        fsm:     ST_IDLE,
        ctrl_en: CTRL_EN_RST,
        default: '0
    };

endpackage
